// ===== rtl/oag_decoder.sv
// Operand address generator: takes 16-bit instruction units, splits the fields and forms addresses.
// Assumes upstream decode supplies mode, class and size with the first unit, and that
// the register file answers reg_value and bit_reg_value in the same cycle as the index.
`timescale 1ns/100ps
`default_nettype none
module oag_decoder (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Instruction unit stream
    input wire logic word_valid,
    input wire logic [15:0] word_data,
    output logic word_ready,
    // Decode qualifiers, sampled with the first unit
    input wire logic [3:0] am_in,
    input wire logic [2:0] cls_in,
    input wire logic [1:0] size_in,
    input wire logic bit_from_reg,
    input wire logic [23:0] pc_in,
    input wire logic mode_1m,
    // Register file read
    output logic [2:0] reg_index,
    input wire logic [31:0] reg_value,
    output logic [3:0] bit_reg_index,
    input wire logic [7:0] bit_reg_value,
    // Memory indirect pointer fetch
    output logic ind_req,
    output logic [23:0] ind_addr,
    input wire logic ind_ack,
    input wire logic [31:0] ind_data,
    // Results
    output logic done,
    output logic illegal,
    output logic [23:0] ea,
    output logic [23:0] target,
    output logic [31:0] imm,
    output logic wb_valid,
    output logic [2:0] wb_index,
    output logic [31:0] wb_data,
    // Fields
    output logic [3:0] operation_field,
    output logic [3:0] op2_field,
    output logic [3:0] cond_field,
    output logic [2:0] rd_index,
    output logic rd_half,
    output logic [1:0] rd_size,
    output logic [2:0] bit_num,
    output logic [1:0] trap_vec,
    output logic [2:0] implied_imm,
    output logic rmw_byte
);
    typedef enum logic [1:0] {S_IDLE, S_EXT, S_CALC, S_IND} oag_state_t;

    oag_state_t state_q; // Sequencer state
    logic [15:0] w0_q; // First unit
    logic [31:0] ext_q; // Extension, first unit high
    logic [1:0] left_q; // Extension units still due
    oag_pkg::oag_am_t am_q; // Captured mode
    oag_pkg::oag_cls_t cls_q; // Captured class
    logic [1:0] size_q; // Captured size
    logic bfr_q; // Bit number from register
    logic m1_q; // Captured 1-Mbyte mode
    logic [23:0] pc_q; // Address after last unit taken
    logic [31:0] regv_q; // Register value used by last result
    logic legal; // Mode allowed for class
    logic [23:0] c_ea; // Calculated operand address
    logic [23:0] c_tgt; // Calculated branch target
    logic [31:0] c_imm; // Calculated immediate
    logic c_wb; // Write-back needed
    logic [31:0] c_wbd; // Write-back value
    logic c_bad; // 24-bit extension top not zero
    logic take; // Unit accepted this cycle

    // Units taken only while collecting
    assign word_ready = (state_q == S_IDLE) || (state_q == S_EXT);
    assign take = word_valid && word_ready;
    // Address register always the low three bits of rm
    assign reg_index = w0_q[oag_pkg::RM_LO +: 3];
    assign bit_reg_index = w0_q[oag_pkg::REG2_LO +: 4];
    assign ind_req = (state_q == S_IND);

    // Sequencer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
        end else begin
            case (state_q)
                // First unit decides how many follow
                S_IDLE: if (take) begin
                    state_q <= (oag_pkg::ext_units(oag_pkg::oag_am_t'(am_in)) == 2'h0) ? S_CALC : S_EXT;
                end
                // Last extension unit ends collection
                S_EXT: if (take && left_q == 2'h1) begin
                    state_q <= S_CALC;
                end
                // Pointer fetch only for memory indirect
                S_CALC: state_q <= (am_q == oag_pkg::AM_MIND && legal) ? S_IND : S_IDLE;
                S_IND: if (ind_ack) begin
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Unit capture and program counter tracking
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            w0_q <= oag_pkg::WORD_RST;
            ext_q <= 32'h00000000;
            left_q <= 2'h0;
            pc_q <= 24'h000000;
        end else if (take) begin
            if (state_q == S_IDLE) begin
                // Opening unit
                w0_q <= word_data;
                ext_q <= 32'h00000000;
                left_q <= oag_pkg::ext_units(oag_pkg::oag_am_t'(am_in));
                pc_q <= pc_in + oag_pkg::UNIT_BYTES;
            end else begin
                // Extension unit, shifts in from the low end
                ext_q <= {ext_q[15:0], word_data};
                left_q <= left_q - 2'h1;
                pc_q <= pc_q + oag_pkg::UNIT_BYTES;
            end
        end
    end

    // Qualifier capture
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            am_q <= oag_pkg::AM_REGD;
            cls_q <= oag_pkg::CL_ARITH;
            size_q <= oag_pkg::SZ_BYTE;
            bfr_q <= 1'b0;
            m1_q <= 1'b0;
        end else if (take && state_q == S_IDLE) begin
            am_q <= oag_pkg::oag_am_t'(am_in);
            cls_q <= oag_pkg::oag_cls_t'(cls_in);
            // Bit modify ops always move one byte
            size_q <= (cls_in == oag_pkg::CL_BIT_SET || cls_in == oag_pkg::CL_BIT_STORE) ? oag_pkg::SZ_BYTE : size_in;
            bfr_q <= bit_from_reg;
            m1_q <= mode_1m;
        end
    end

    // Mode legality per class
    always_comb begin
        case (cls_q)
            // Register or immediate only
            oag_pkg::CL_ARITH: legal = am_q == oag_pkg::AM_REGD || am_q == oag_pkg::AM_IMM8 ||
                am_q == oag_pkg::AM_IMM16 || am_q == oag_pkg::AM_IMM32;
            // Everything but relative and memory indirect
            oag_pkg::CL_XFER: legal = am_q != oag_pkg::AM_PCREL8 && am_q != oag_pkg::AM_PCREL16 &&
                am_q != oag_pkg::AM_MIND;
            // Stores take bit number from the immediate only
            oag_pkg::CL_BIT_SET, oag_pkg::CL_BIT_TEST, oag_pkg::CL_BIT_STORE:
                legal = (am_q == oag_pkg::AM_REGD || am_q == oag_pkg::AM_IND || am_q == oag_pkg::AM_ABS8) &&
                    !(bfr_q && cls_q == oag_pkg::CL_BIT_STORE);
            oag_pkg::CL_BRANCH: legal = am_q == oag_pkg::AM_PCREL8 || am_q == oag_pkg::AM_PCREL16;
            oag_pkg::CL_JUMP: legal = am_q == oag_pkg::AM_IND || am_q == oag_pkg::AM_ABS24 ||
                am_q == oag_pkg::AM_MIND;
            default: legal = 1'b0;
        endcase
    end

    // Address arithmetic
    oag_ea_calc u_calc (
        .am(am_q),
        .size(size_q),
        .w0(w0_q),
        .ext(ext_q),
        .regv(reg_value),
        .pcn(pc_q),
        .ind_data(ind_data),
        .m1(m1_q),
        .ea(c_ea),
        .target(c_tgt),
        .imm(c_imm),
        .wb_en(c_wb),
        .wb_data(c_wbd),
        .bad_ext(c_bad)
    );

    // Pointer address held for the whole fetch
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ind_addr <= 24'h000000;
        end else if (state_q == S_CALC) begin
            ind_addr <= c_ea;
        end
    end

    // Result registers, updated when a decode completes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
            illegal <= 1'b0;
            ea <= 24'h000000;
            target <= 24'h000000;
            imm <= 32'h00000000;
            wb_valid <= 1'b0;
            wb_index <= 3'h0;
            wb_data <= 32'h00000000;
            regv_q <= 32'h00000000;
        end else begin
            done <= 1'b0;
            wb_valid <= 1'b0;
            if (state_q == S_CALC && !(am_q == oag_pkg::AM_MIND && legal)) begin
                // Single-step result
                done <= 1'b1;
                illegal <= !legal || c_bad;
                ea <= c_ea;
                target <= c_tgt;
                imm <= c_imm;
                wb_valid <= c_wb && legal;
                wb_index <= reg_index;
                wb_data <= c_wbd;
                regv_q <= reg_value;
            end else if (state_q == S_IND && ind_ack) begin
                // Target from fetched pointer
                done <= 1'b1;
                illegal <= 1'b0;
                ea <= ind_addr;
                target <= c_tgt;
                imm <= 32'h00000000;
            end
        end
    end

    // Field extraction, stable from capture
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            operation_field <= 4'h0;
            op2_field <= 4'h0;
            cond_field <= 4'h0;
            rd_index <= 3'h0;
            rd_half <= 1'b0;
            rd_size <= oag_pkg::SZ_BYTE;
            bit_num <= 3'h0;
            trap_vec <= 2'h0;
            implied_imm <= 3'h0;
            rmw_byte <= 1'b0;
        end else if (state_q == S_CALC) begin
            operation_field <= w0_q[oag_pkg::OP_LO +: 4];
            op2_field <= w0_q[oag_pkg::OP2_LO +: 4];
            cond_field <= (cls_q == oag_pkg::CL_BRANCH) ? w0_q[oag_pkg::OP2_LO +: 4] : 4'h0;
            // Byte: high/low half; word: general/extended half; long: whole
            rd_index <= w0_q[oag_pkg::RM_LO +: 3];
            rd_half <= (size_q == oag_pkg::SZ_LONG) ? 1'b0 : w0_q[oag_pkg::RM_LO + 3];
            rd_size <= size_q;
            bit_num <= bfr_q ? bit_reg_value[2:0] : w0_q[oag_pkg::REG2_LO +: 3];
            trap_vec <= w0_q[oag_pkg::REG2_LO +: 2];
            // Implied value 1, 2 or 4
            case (w0_q[oag_pkg::REG2_LO + 2 +: 2])
                2'h0: implied_imm <= 3'h1;
                2'h1: implied_imm <= 3'h2;
                default: implied_imm <= 3'h4;
            endcase
            rmw_byte <= (cls_q == oag_pkg::CL_BIT_SET || cls_q == oag_pkg::CL_BIT_STORE);
        end
    end

    // Checks on the formed results
    a_done_single: assert property (@(posedge clock) disable iff (rst) done |=> !done) else $error("done longer than one cycle");
    // Unit sequencing: long immediate collects two more units, last one closes collection
    a_unit_count: assert property (@(posedge clock) disable iff (rst)
        (take && state_q == S_IDLE && am_in == oag_pkg::AM_IMM32) |=> (state_q == S_EXT && left_q == 2'h2))
        else $error("long immediate did not expect two units");
    a_ext_close: assert property (@(posedge clock) disable iff (rst)
        (take && state_q == S_EXT && left_q == 2'h1) |=> (state_q == S_CALC))
        else $error("last extension unit did not end collection");
    a_ret_idle: assert property (@(posedge clock) disable iff (rst) done |-> word_ready)
        else $error("not ready for next unit with done");
    a_addr_1m: assert property (@(posedge clock) disable iff (rst) (done && m1_q) |-> (ea[23:20] == 4'h0 && target[23:20] == 4'h0))
        else $error("1-Mbyte address not truncated");
    a_even_align: assert property (@(posedge clock) disable iff (rst)
        (done && size_q != oag_pkg::SZ_BYTE && am_q != oag_pkg::AM_IMM8) |-> !ea[0] && !target[0])
        else $error("odd word address");
    a_abs8_fill: assert property (@(posedge clock) disable iff (rst)
        (done && am_q == oag_pkg::AM_ABS8 && !m1_q) |-> ea[23:1] == {oag_pkg::ABS8_FILL, w0_q[7:1]})
        else $error("short absolute not filled with ones");
    a_abs16_sext: assert property (@(posedge clock) disable iff (rst)
        (done && am_q == oag_pkg::AM_ABS16 && !m1_q) |-> ea[23:16] == {8{ext_q[15]}})
        else $error("16-bit absolute not sign extended");
    a_postinc_step: assert property (@(posedge clock) disable iff (rst)
        (done && am_q == oag_pkg::AM_POSTINC && !illegal) |-> wb_valid && wb_data == regv_q + oag_pkg::size_step(size_q)
        && ea[23:1] == oag_pkg::fix_addr(regv_q[23:0], 1'b0, m1_q) >> 1)
        else $error("post-increment wrong");
    a_predec_step: assert property (@(posedge clock) disable iff (rst)
        (done && am_q == oag_pkg::AM_PREDEC && !illegal) |-> wb_valid && wb_data == regv_q - oag_pkg::size_step(size_q)
        && ea[23:1] == oag_pkg::fix_addr(wb_data[23:0], 1'b0, m1_q) >> 1)
        else $error("pre-decrement wrong");
    a_pcrel_target: assert property (@(posedge clock) disable iff (rst)
        (done && am_q == oag_pkg::AM_PCREL8) |-> target == oag_pkg::fix_addr(pc_q + oag_pkg::sext8(w0_q[7:0]), 1'b1, m1_q))
        else $error("relative target wrong");
    a_mind_fetch: assert property (@(posedge clock) disable iff (rst)
        (ind_req && ind_ack) |=> done && target == oag_pkg::fix_addr($past(ind_data[23:0]), 1'b1, m1_q) && ind_addr[23:8] == 16'h0000)
        else $error("memory indirect target wrong");
    a_rmw_byte: assert property (@(posedge clock) disable iff (rst)
        (done && (cls_q == oag_pkg::CL_BIT_SET || cls_q == oag_pkg::CL_BIT_STORE)) |-> rmw_byte && rd_size == oag_pkg::SZ_BYTE)
        else $error("bit modify not byte wide");
    a_arith_modes: assert property (@(posedge clock) disable iff (rst)
        (done && cls_q == oag_pkg::CL_ARITH && am_q == oag_pkg::AM_IND) |-> illegal)
        else $error("arithmetic with memory mode accepted");
    // Bit operand, immediate and pointer hold checks
    a_bit_store_reg: assert property (@(posedge clock) disable iff (rst)
        (done && cls_q == oag_pkg::CL_BIT_STORE && bfr_q) |-> illegal)
        else $error("store with register bit number accepted");
    a_imm8_value: assert property (@(posedge clock) disable iff (rst)
        (done && am_q == oag_pkg::AM_IMM8) |-> imm == {24'h000000, w0_q[7:0]})
        else $error("short immediate wrong");
    a_ind_hold: assert property (@(posedge clock) disable iff (rst)
        (ind_req && !ind_ack) |=> ind_req && $stable(ind_addr))
        else $error("pointer fetch dropped before answer");
endmodule // oag_decoder
`default_nettype wire

// ===== rtl/oag_pkg.sv
// Shared types, field layout, constants and address helpers for the operand address generator.
// Assumes a 24-bit address space and 16-bit instruction units.
`default_nettype none
package oag_pkg;
    // Addressing modes, sub-forms by extension length
    typedef enum logic [3:0] {
        AM_REGD, AM_IND, AM_DISP16, AM_DISP24, AM_POSTINC, AM_PREDEC, AM_ABS8, AM_ABS16,
        AM_ABS24, AM_IMM8, AM_IMM16, AM_IMM32, AM_PCREL8, AM_PCREL16, AM_MIND
    } oag_am_t;
    // Instruction classes that limit the modes
    typedef enum logic [2:0] {
        CL_ARITH, CL_XFER, CL_BIT_SET, CL_BIT_STORE, CL_BIT_TEST, CL_BRANCH, CL_JUMP
    } oag_cls_t;
    // Operand sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    // Field positions in the first unit
    localparam int OP_LO = 12;
    localparam int OP2_LO = 8;
    localparam int REG2_LO = 4;
    localparam int RM_LO = 0;
    // Fixed values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] ABS8_FILL = 16'hFFFF;
    localparam logic [15:0] MIND_TOP = 16'h0000;
    localparam logic [7:0] EXT24_TOP = 8'h00;
    localparam logic [23:0] M1_MASK = 24'h0FFFFF;
    localparam logic [23:0] UNIT_BYTES = 24'h000002;

    // Extension units following the first unit
    function automatic logic [1:0] ext_units(input oag_am_t am);
        case (am)
            AM_DISP16, AM_ABS16, AM_IMM16, AM_PCREL16: ext_units = 2'h1;
            AM_DISP24, AM_ABS24, AM_IMM32: ext_units = 2'h2;
            default: ext_units = 2'h0;
        endcase
    endfunction

    // Register step for increment and decrement
    function automatic logic [31:0] size_step(input logic [1:0] sz);
        case (sz)
            SZ_BYTE: size_step = 32'h00000001;
            SZ_WORD: size_step = 32'h00000002;
            default: size_step = 32'h00000004;
        endcase
    endfunction

    // Even forcing and 1-Mbyte truncation of a formed address
    function automatic logic [23:0] fix_addr(input logic [23:0] a, input logic even, input logic m1);
        logic [23:0] t;
        t = {a[23:1], a[0] & ~even};
        fix_addr = m1 ? (t & M1_MASK) : t;
    endfunction

    // Sign extension of short displacements
    function automatic logic [23:0] sext8(input logic [7:0] d);
        sext8 = {{16{d[7]}}, d};
    endfunction
    function automatic logic [23:0] sext16(input logic [15:0] d);
        sext16 = {{8{d[15]}}, d};
    endfunction
endpackage
`default_nettype wire

// ===== rtl/oag_ea_calc.sv
// Combinational address arithmetic for every addressing mode.
// Assumes the caller holds all inputs stable for the cycle in which it samples the outputs.
`timescale 1ns/100ps
`default_nettype none
module oag_ea_calc (
    // Decoded instruction
    input wire logic [3:0] am,
    input wire logic [1:0] size,
    input wire logic [15:0] w0,
    input wire logic [31:0] ext,
    // Operand sources
    input wire logic [31:0] regv,
    input wire logic [23:0] pcn,
    input wire logic [31:0] ind_data,
    input wire logic m1,
    // Results
    output logic [23:0] ea,
    output logic [23:0] target,
    output logic [31:0] imm,
    output logic wb_en,
    output logic [31:0] wb_data,
    output logic bad_ext
);
    logic [23:0] raw; // Unmasked operand address
    logic [23:0] traw; // Unmasked branch target
    logic [31:0] sum; // Register plus displacement
    logic even; // Operand needs even address

    // Address forming per mode
    always_comb begin
        raw = 24'h000000;
        traw = 24'h000000;
        imm = 32'h00000000;
        wb_en = 1'b0;
        wb_data = 32'h00000000;
        bad_ext = 1'b0;
        sum = regv + ((am == oag_pkg::AM_DISP16) ? {{16{ext[15]}}, ext[15:0]} : ext);
        case (am)
            // Register low bits only
            oag_pkg::AM_IND: raw = regv[23:0];
            oag_pkg::AM_DISP16: raw = sum[23:0];
            oag_pkg::AM_DISP24: begin
                raw = sum[23:0];
                bad_ext = (ext[31:24] != oag_pkg::EXT24_TOP);
            end
            // Access first, whole register stepped after
            oag_pkg::AM_POSTINC: begin
                raw = regv[23:0];
                wb_en = 1'b1;
                wb_data = regv + oag_pkg::size_step(size);
            end
            // Step first, stepped value is the address
            oag_pkg::AM_PREDEC: begin
                wb_en = 1'b1;
                wb_data = regv - oag_pkg::size_step(size);
                raw = wb_data[23:0];
            end
            oag_pkg::AM_ABS8: raw = {oag_pkg::ABS8_FILL, w0[7:0]};
            oag_pkg::AM_ABS16: raw = oag_pkg::sext16(ext[15:0]);
            oag_pkg::AM_ABS24: begin
                raw = ext[23:0];
                bad_ext = (ext[31:24] != oag_pkg::EXT24_TOP);
            end
            // Operand straight from the units
            oag_pkg::AM_IMM8: imm = {24'h000000, w0[7:0]};
            oag_pkg::AM_IMM16: imm = {16'h0000, ext[15:0]};
            oag_pkg::AM_IMM32: imm = ext;
            // Next-instruction address plus displacement
            oag_pkg::AM_PCREL8: traw = pcn + oag_pkg::sext8(w0[7:0]);
            oag_pkg::AM_PCREL16: traw = pcn + oag_pkg::sext16(ext[15:0]);
            // Pointer in page zero, top byte of the longword dropped
            oag_pkg::AM_MIND: begin
                raw = {oag_pkg::MIND_TOP, w0[7:0]};
                traw = ind_data[23:0];
            end
            default: raw = 24'h000000;
        endcase
    end

    // Longword pointer fetch is always even
    assign even = (size != oag_pkg::SZ_BYTE) || (am == oag_pkg::AM_MIND);
    assign ea = oag_pkg::fix_addr(raw, even, m1);
    assign target = oag_pkg::fix_addr(traw, 1'b1, m1);
endmodule // oag_ea_calc
`default_nettype wire

// ===== dv/oag_partner.sv
// Far-side model: register file reads and pointer memory.
// Assumes the decoder reads registers in the cycle it drives the index.
`timescale 1ns/100ps
`default_nettype none
module oag_partner (
    // Clock, reset, set-up
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] preset,
    input wire logic slow,
    // Register reads
    input wire logic [2:0] reg_index,
    output logic [31:0] reg_value,
    input wire logic [3:0] bit_reg_index,
    output logic [7:0] bit_reg_value,
    // Pointer fetch
    input wire logic ind_req,
    input wire logic [23:0] ind_addr,
    output logic ind_ack,
    output logic [31:0] ind_data
);
    logic [3:0] wait_q; // Cycles spent waiting
    // Only register 3 holds the preset
    assign reg_value = (reg_index == 3'h3) ? preset : ~preset;
    // Bit number read back inverted, so register and immediate forms differ
    assign bit_reg_value = {4'h0, ~bit_reg_index};
    // Longword answer, prompt or slow; data toggles off the ack
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_q <= 4'h0;
            ind_ack <= 1'b0;
            ind_data <= 32'h0;
        end else if (ind_req && !ind_ack && wait_q >= (slow ? 4'h5 : 4'h0)) begin
            ind_ack <= 1'b1;
            ind_data <= {8'hA5, 8'h40, ind_addr[15:0]};
            wait_q <= 4'h0;
        end else begin
            ind_ack <= 1'b0;
            ind_data <= ~ind_data;
            wait_q <= ind_req ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule // oag_partner
`default_nettype wire

// ===== dv/test_operand_address_generator.sv
// Self-checking bench for the operand address generator.
// Assumes the partner model answers register and pointer reads.
`timescale 1ns/100ps
`default_nettype none
module test_operand_address_generator;
    // Stimulus
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic word_valid = 1'b0;
    logic [15:0] word_data = 16'h0000;
    logic [3:0] am_in = 4'h0;
    logic [2:0] cls_in = 3'h0;
    logic [1:0] size_in = 2'h0;
    logic bit_from_reg = 1'b0;
    logic [23:0] pc_in = 24'h001000;
    logic mode_1m = 1'b0;
    logic [31:0] preset = 32'hAB123457;
    logic slow = 1'b0;
    // Observed
    logic word_ready, ind_req, ind_ack, done, illegal, wb_valid, rd_half, rmw_byte;
    logic [2:0] reg_index, wb_index, rd_index, bit_num, implied_imm;
    logic [3:0] bit_reg_index, operation_field, op2_field, cond_field;
    logic [7:0] bit_reg_value;
    logic [23:0] ind_addr, ea, target;
    logic [31:0] reg_value, ind_data, imm, wb_data;
    logic [1:0] rd_size, trap_vec;
    int bad_count = 0;
    int n_tests = 0;
    always #12.5 clock = ~clock;
    oag_decoder DUT (.clock, .rst, .word_valid, .word_data, .word_ready, .am_in, .cls_in, .size_in,
        .bit_from_reg, .pc_in, .mode_1m, .reg_index, .reg_value, .bit_reg_index, .bit_reg_value,
        .ind_req, .ind_addr, .ind_ack, .ind_data, .done, .illegal, .ea, .target, .imm, .wb_valid,
        .wb_index, .wb_data, .operation_field, .op2_field, .cond_field, .rd_index, .rd_half, .rd_size,
        .bit_num, .trap_vec, .implied_imm, .rmw_byte);
    oag_partner far_end (.clock, .rst, .preset, .slow, .reg_index, .reg_value, .bit_reg_index,
        .bit_reg_value, .ind_req, .ind_addr, .ind_ack, .ind_data);
    // Counts, verdict, stop
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // Offer a unit, hold it until an edge takes it
    task automatic put(input logic [15:0] w);
        int i;
        word_valid <= 1'b1;
        word_data <= w;
        for (i = 0; i < 20; i++) begin
            @(negedge clock);
            if (word_ready === 1'b1) break;
        end
        if (word_ready !== 1'b1) begin
            bad_count++;
            end_of_test();
        end
        @(posedge clock);
    endtask
    // Whole instruction, then wait for done
    task automatic run(input logic [3:0] am, input logic [2:0] cls, input logic [1:0] sz,
        input logic [15:0] w0, input logic [31:0] ext, input int n);
        int i;
        @(posedge clock);
        am_in <= am;
        cls_in <= cls;
        size_in <= sz;
        put(w0);
        if (n == 2) put(ext[31:16]);
        if (n > 0) put(ext[15:0]);
        word_valid <= 1'b0;
        for (i = 0; i < 40 && done !== 1'b1; i++) @(negedge clock);
        if (done !== 1'b1) begin
            bad_count++;
            end_of_test();
        end
    endtask
    // Absolute forms, 1-Mbyte mask, bad 24-bit top byte
    task automatic t_abs();
        run(oag_pkg::AM_ABS16, oag_pkg::CL_XFER, oag_pkg::SZ_BYTE, 16'h6A21, 32'h8001, 1);
        chk("ea16", {8'h0, ea}, 32'h00FF8001);
        chk("op", {24'h0, operation_field, op2_field}, 32'h6A);
        run(oag_pkg::AM_ABS8, oag_pkg::CL_BIT_SET, oag_pkg::SZ_BYTE, 16'h7D55, 32'h0, 0);
        chk("ea8", {8'h0, ea}, 32'h00FFFF55);
        chk("bit", {28'h0, rmw_byte, bit_num}, 32'hD);
        mode_1m <= 1'b1;
        run(oag_pkg::AM_ABS24, oag_pkg::CL_XFER, oag_pkg::SZ_BYTE, 16'h6A00, 32'h00F12345, 2);
        chk("ea1m", {8'h0, ea}, 32'h00012345);
        mode_1m <= 1'b0;
        run(oag_pkg::AM_ABS24, oag_pkg::CL_XFER, oag_pkg::SZ_BYTE, 16'h6A00, 32'h01000000, 2);
        chk("top byte", {31'h0, illegal}, 32'h1);
        run(oag_pkg::AM_IND, oag_pkg::CL_ARITH, oag_pkg::SZ_BYTE, 16'h0903, 32'h0, 0);
        chk("class", {31'h0, illegal}, 32'h1);
    endtask
    // Register direct, indirect, displacement
    task automatic t_reg();
        run(oag_pkg::AM_REGD, oag_pkg::CL_ARITH, oag_pkg::SZ_BYTE, 16'h080B, 32'h0, 0);
        chk("rd", {28'h0, rd_half, rd_index}, 32'hB);
        run(oag_pkg::AM_IND, oag_pkg::CL_XFER, oag_pkg::SZ_WORD, 16'h6903, 32'h0, 0);
        chk("ind", {8'h0, ea}, 32'h00123456);
        run(oag_pkg::AM_DISP16, oag_pkg::CL_XFER, oag_pkg::SZ_BYTE, 16'h6E03, 32'hFFFE, 1);
        chk("disp", {8'h0, ea}, 32'h00123455);
    endtask
    // Post-increment and pre-decrement write-back
    task automatic t_step();
        preset <= 32'h00100000;
        run(oag_pkg::AM_POSTINC, oag_pkg::CL_XFER, oag_pkg::SZ_LONG, 16'h6D03, 32'h0, 0);
        chk("post ea", {8'h0, ea}, 32'h00100000);
        chk("post wb", wb_data, 32'h00100004);
        chk("post idx", {28'h0, wb_valid, wb_index}, 32'hB);
        run(oag_pkg::AM_PREDEC, oag_pkg::CL_XFER, oag_pkg::SZ_WORD, 16'h6D03, 32'h0, 0);
        chk("pre ea", {8'h0, ea}, 32'h000FFFFE);
        chk("pre wb", wb_data, 32'h000FFFFE);
    endtask
    // Relative branches, memory indirect, immediates
    task automatic t_flow();
        run(oag_pkg::AM_PCREL8, oag_pkg::CL_BRANCH, oag_pkg::SZ_BYTE, 16'h4780, 32'h0, 0);
        chk("rel8", {8'h0, target}, 32'h00000F82);
        chk("cond", {28'h0, cond_field}, 32'h7);
        run(oag_pkg::AM_PCREL16, oag_pkg::CL_BRANCH, oag_pkg::SZ_BYTE, 16'h5C00, 32'h8002, 1);
        chk("rel16", {8'h0, target}, 32'h00FF9006);
        slow <= 1'b1;
        run(oag_pkg::AM_MIND, oag_pkg::CL_JUMP, oag_pkg::SZ_BYTE, 16'h5D11, 32'h0, 0);
        chk("ptr", {8'h0, ind_addr}, 32'h00000010);
        chk("mind", {8'h0, target}, 32'h00400010);
        run(oag_pkg::AM_IMM32, oag_pkg::CL_ARITH, oag_pkg::SZ_LONG, 16'h7A60, 32'h89ABCDEF, 2);
        chk("imm", imm, 32'h89ABCDEF);
        chk("implied", {27'h0, implied_imm, trap_vec}, 32'hA);
    endtask
    // Short immediate, 24-bit displacement, register bit number, refused store form
    task automatic t_more();
        run(oag_pkg::AM_IMM8, oag_pkg::CL_ARITH, oag_pkg::SZ_WORD, 16'h79C4, 32'h0, 0);
        chk("imm8", imm, 32'h000000C4);
        chk("size", {30'h0, rd_size}, 32'h1);
        run(oag_pkg::AM_DISP24, oag_pkg::CL_XFER, oag_pkg::SZ_BYTE, 16'h7803, 32'h00000011, 2);
        chk("disp24", {7'h0, illegal, ea}, 32'h00100011);
        bit_from_reg <= 1'b1;
        run(oag_pkg::AM_IND, oag_pkg::CL_BIT_TEST, oag_pkg::SZ_BYTE, 16'h7353, 32'h0, 0);
        chk("bitreg", {28'h0, illegal, bit_num}, 32'h2);
        run(oag_pkg::AM_REGD, oag_pkg::CL_BIT_STORE, oag_pkg::SZ_WORD, 16'h6753, 32'h0, 0);
        chk("bitst", {29'h0, illegal, rmw_byte, rd_size[0]}, 32'h6);
        bit_from_reg <= 1'b0;
    endtask
    // Reset, then every scenario
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        t_abs();
        t_reg();
        t_step();
        t_flow();
        t_more();
        end_of_test();
    end
endmodule // test_operand_address_generator
`default_nettype wire
